/* common/ssir_pkg.sv */
// package: register map, field layout and carrier types of the spi status block
//
// Functional notes
// RULE1 - select field used only variable-select master
// RULE2 - no decode: lowest zero bit picks line
// RULE3 - decode on: field drives select lines directly
// RULE4 - rx full sets on load, clears on read
// RULE5 - tx empty clears on write, sets on move
// RULE6 - tx empty zero when disabled, enable sets
// RULE7 - mode fault sticky until status read
// RULE8 - overrun on second load without read
// RULE9 - bit 4 mirrors receive channel done
// RULE10 - bit 5 mirrors transmit channel done
// RULE11 - bit 16 shows enabled; status resets zero
// RULE12 - enable-set register sets mask bits
// RULE13 - enable-clear register clears mask bits
// RULE14 - mask register readable, resets zero
// RULE15 - software loads receive pointer before transfer
// RULE16 - count zero stops, nonzero moves words
// RULE17 - irq when status and mask both set
// RULE18 - store advances pointer, decrements count, done
package ssir_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_RX_DATA = 8'h08;
  localparam logic [7:0] OFF_TX_DATA = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_SET = 8'h14;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;
  localparam logic [7:0] OFF_RX_ADDR = 8'h20;
  localparam logic [7:0] OFF_RX_COUNT = 8'h24;
  localparam logic [7:0] OFF_MODE_CTL = 8'h40;
  localparam int unsigned BIT_RX_FULL = 0;
  localparam int unsigned BIT_TX_EMPTY = 1;
  localparam int unsigned BIT_MODE_FAULT = 2;
  localparam int unsigned BIT_OVERRUN = 3;
  localparam int unsigned BIT_RX_DONE = 4;
  localparam int unsigned BIT_TX_DONE = 5;
  localparam int unsigned BIT_ENABLED = 16;
  localparam int unsigned SEL_LSB = 16;
  localparam int unsigned MODE_MASTER = 0;
  localparam int unsigned MODE_VARIABLE = 1;
  localparam int unsigned MODE_DECODE = 2;
  localparam logic [31:0] RX_ADDR_STEP = 32'h00000004;
  localparam logic [5:0] MASK_RESET = 6'h00;
  localparam logic [3:0] SEL_IDLE = 4'hF;
  localparam logic [3:0] FIXED_SEL_RESET = 4'hF;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ssir_bus_t;

  typedef struct packed {
    logic enable_cmd;
    logic disable_cmd;
    logic rx_load;
    logic [15:0] rx_word;
    logic tx_load;
    logic mode_fault;
    logic tx_done;
  } ssir_core_t;
endpackage

/* design/ssir_sync.sv */
// two-flop synchroniser for outside levels
`timescale 1ns/1ps
module ssir_sync import ssir_pkg::*; #(
  parameter int unsigned W = 1
) (
  input wire logic clock, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic clk_en, // freezes state when low
  input wire logic [W-1:0] async_in, // level from outside
  output logic [W-1:0] sync_out // synchronised level
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } ssir_sync_st_t;
  ssir_sync_st_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end
  assign sync_out = s_q.sync;
endmodule // ssir_sync

/* design/ssir_top.sv */
// spi status, interrupt mask, select field and receive channel registers
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module ssir_top import ssir_pkg::*; (
  input wire logic clock, // 100 MHz system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic clk_en, // freezes all state when low
  input wire logic [ADDR_W-1:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire logic core_enable_cmd, // enable command pulse
  input wire logic core_disable_cmd, // disable command pulse
  input wire logic core_rx_load, // word moved serializer to rx reg
  input wire logic [15:0] core_rx_word, // received word
  input wire logic core_tx_load, // tx word moved into serializer
  input wire logic core_tx_done, // transmit channel end level
  input wire logic fault_pin, // mode fault level from pin
  output logic [3:0] slave_select_lines, // active-low selects
  output logic [3:0] tx_select_field, // select field of last tx word
  output logic tx_word_valid, // pulse: tx data written
  output logic [15:0] tx_word, // tx data
  output logic dma_wr, // pulse: store word to memory
  output logic [31:0] dma_addr, // memory address of store
  output logic [15:0] dma_data, // word stored
  output logic irq // level interrupt request
);
  typedef struct packed {
    logic [31:0] rdata;
    logic rx_full_flag;
    logic tx_empty_flag;
    logic mode_fault_flag;
    logic rx_overrun_flag;
    logic enabled_state_flag;
    logic [5:0] irq_mask;
    logic [31:0] rx_buffer_address_field;
    logic [15:0] rx_buffer_count_field;
    logic rx_channel_done;
    logic [15:0] rx_data_register;
    logic [3:0] sel_field;
    logic master_mode;
    logic variable_select_mode;
    logic select_decode_on;
    logic [3:0] fixed_select;
    logic [3:0] sel_lines;
    logic tx_valid;
    logic [15:0] tx_data;
    logic dma_wr;
    logic [31:0] dma_addr;
    logic [15:0] dma_data;
    logic fault_seen;
    logic irq;
  } ssir_state_t;

  ssir_state_t s_q, s_d;
  ssir_bus_t bus;
  ssir_core_t core;
  logic fault_sync;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign core = '{enable_cmd: core_enable_cmd,
                  disable_cmd: core_disable_cmd,
                  rx_load: core_rx_load, rx_word: core_rx_word,
                  tx_load: core_tx_load, mode_fault: fault_sync,
                  tx_done: core_tx_done};

  // the fault pin is asynchronous, so it is synchronised before edge detect
  ssir_sync #(.W(1)) u_fault_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in(fault_pin),
    .sync_out(fault_sync)
  );

  // lowest zero bit picks a single active-low line
  function automatic logic [3:0] sel_onehot(input logic [3:0] f);
    logic [3:0] r;
    r = SEL_IDLE;
    if (!f[0]) r = 4'hE;
    else if (!f[1]) r = 4'hD;
    else if (!f[2]) r = 4'hB;
    else if (!f[3]) r = 4'h7;
    return r;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    return a == off[ADDR_W-1:0];
  endfunction

  function automatic logic [5:0] status_bits(input ssir_state_t s);
    logic [5:0] b;
    b = '0;
    b[BIT_RX_FULL] = s.rx_full_flag;
    b[BIT_TX_EMPTY] = s.tx_empty_flag;
    b[BIT_MODE_FAULT] = s.mode_fault_flag;
    b[BIT_OVERRUN] = s.rx_overrun_flag;
    b[BIT_RX_DONE] = s.rx_channel_done; // RULE9
    b[BIT_TX_DONE] = core_tx_done; // RULE10
    return b;
  endfunction

  always_comb begin
    logic [3:0] use_field;
    logic rx_rd;
    logic st_rd;
    logic [5:0] st;
    logic [5:0] next_st;
    use_field = '0;
    next_st = '0;
    rx_rd = bus.rd && hit(bus.addr, OFF_RX_DATA);
    st_rd = bus.rd && hit(bus.addr, OFF_STATUS);
    st = status_bits(s_q);
    s_d = s_q;
    s_d.tx_valid = 1'b0;
    s_d.dma_wr = 1'b0;
    s_d.fault_seen = core.mode_fault;

    // read data: one cycle after the strobe, zero otherwise
    s_d.rdata = '0;
    if (bus.rd) begin
      unique case (1'b1)
        hit(bus.addr, OFF_RX_DATA):
          s_d.rdata = {12'h000, s_q.sel_lines & {4{s_q.master_mode}},
                       s_q.rx_data_register};
        hit(bus.addr, OFF_STATUS): begin
          s_d.rdata[5:0] = st;
          s_d.rdata[BIT_ENABLED] = s_q.enabled_state_flag; // RULE11
        end
        hit(bus.addr, OFF_IRQ_MASK):
          s_d.rdata[5:0] = s_q.irq_mask; // RULE14
        hit(bus.addr, OFF_RX_ADDR):
          s_d.rdata = s_q.rx_buffer_address_field;
        hit(bus.addr, OFF_RX_COUNT):
          s_d.rdata[15:0] = s_q.rx_buffer_count_field;
        hit(bus.addr, OFF_MODE_CTL):
          s_d.rdata = {12'h000, s_q.fixed_select, 13'h0000,
                       s_q.select_decode_on, s_q.variable_select_mode,
                       s_q.master_mode};
        default: s_d.rdata = '0;
      endcase
    end

    // enable state; disable wins when both commands arrive together
    if (core.disable_cmd) begin
      s_d.enabled_state_flag = 1'b0;
    end else if (core.enable_cmd) begin
      s_d.enabled_state_flag = 1'b1;
    end

    // rx full and overrun; a load in the read cycle keeps the flag set
    if (rx_rd) s_d.rx_full_flag = 1'b0; // RULE4
    if (st_rd) s_d.rx_overrun_flag = 1'b0; // RULE8
    if (st_rd) s_d.mode_fault_flag = 1'b0; // RULE7
    if (core.rx_load) begin
      s_d.rx_full_flag = 1'b1; // RULE4
      s_d.rx_data_register = core.rx_word;
      if (s_q.rx_full_flag && !rx_rd) s_d.rx_overrun_flag = 1'b1; // RULE8
    end
    if (core.mode_fault && !s_q.fault_seen) begin
      s_d.mode_fault_flag = 1'b1; // RULE7
    end

    // tx data write: clears tx empty and latches the select field
    if (bus.wr && hit(bus.addr, OFF_TX_DATA)) begin
      s_d.tx_empty_flag = 1'b0; // RULE5
      s_d.tx_valid = 1'b1;
      s_d.tx_data = bus.wdata[15:0];
      s_d.sel_field = bus.wdata[SEL_LSB +: 4];
    end
    if (core.tx_load) s_d.tx_empty_flag = 1'b1; // RULE5
    if (core.enable_cmd && !core.disable_cmd) begin
      s_d.tx_empty_flag = 1'b1; // RULE6
    end
    if (core.disable_cmd || !s_d.enabled_state_flag) begin
      s_d.tx_empty_flag = 1'b0; // RULE6
    end

    // select lines: field only honoured in variable master mode
    if (s_q.master_mode && s_q.variable_select_mode) begin
      use_field = s_q.sel_field; // RULE1
    end else begin
      use_field = s_q.fixed_select; // RULE1
    end
    if (s_q.select_decode_on) begin
      s_d.sel_lines = use_field; // RULE3
    end else begin
      s_d.sel_lines = sel_onehot(use_field); // RULE2
    end

    // register writes
    if (bus.wr) begin
      if (hit(bus.addr, OFF_IRQ_SET)) begin
        s_d.irq_mask = s_q.irq_mask | bus.wdata[5:0]; // RULE12
      end
      if (hit(bus.addr, OFF_IRQ_CLR)) begin
        s_d.irq_mask = s_q.irq_mask & ~bus.wdata[5:0]; // RULE13
      end
      if (hit(bus.addr, OFF_RX_ADDR)) begin
        s_d.rx_buffer_address_field = bus.wdata; // RULE15
      end
      if (hit(bus.addr, OFF_MODE_CTL)) begin
        s_d.master_mode = bus.wdata[MODE_MASTER];
        s_d.variable_select_mode = bus.wdata[MODE_VARIABLE];
        s_d.select_decode_on = bus.wdata[MODE_DECODE];
        s_d.fixed_select = bus.wdata[SEL_LSB +: 4];
      end
    end

    // receive channel: moves one word per full flag while count nonzero;
    // the store itself reads the rx register, which frees it
    if (bus.wr && hit(bus.addr, OFF_RX_COUNT)) begin
      s_d.rx_buffer_count_field = bus.wdata[15:0]; // RULE16
      s_d.rx_channel_done = 1'b0; // RULE9
    end else if (s_q.rx_full_flag && s_q.rx_buffer_count_field != 16'h0000
                 && !core.rx_load) begin
      s_d.dma_wr = 1'b1; // RULE16
      s_d.dma_addr = s_q.rx_buffer_address_field;
      s_d.dma_data = s_q.rx_data_register;
      s_d.rx_full_flag = 1'b0;
      s_d.rx_buffer_address_field =
        s_q.rx_buffer_address_field + RX_ADDR_STEP; // RULE18
      s_d.rx_buffer_count_field =
        s_q.rx_buffer_count_field - 16'h0001; // RULE18
      // done only on the last store, so a count idle since reset reads zero
      s_d.rx_channel_done =
        s_q.rx_buffer_count_field == 16'h0001; // RULE18
      if (bus.wr && hit(bus.addr, OFF_RX_ADDR)) begin
        s_d.rx_buffer_address_field = bus.wdata;
      end
    end

    // interrupt from the next state of each flag; tx done from its live level under present and next mask
    next_st = status_bits(s_d);
    next_st[BIT_TX_DONE] = s_q.irq_mask[BIT_TX_DONE] & core_tx_done;
    s_d.irq = |(next_st & s_d.irq_mask); // RULE17
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.irq_mask <= MASK_RESET; // RULE14
      s_q.fixed_select <= FIXED_SEL_RESET;
      s_q.sel_field <= FIXED_SEL_RESET;
      s_q.sel_lines <= SEL_IDLE;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign slave_select_lines = s_q.sel_lines;
  assign tx_select_field = s_q.sel_field;
  assign tx_word_valid = s_q.tx_valid;
  assign tx_word = s_q.tx_data;
  assign dma_wr = s_q.dma_wr;
  assign dma_addr = s_q.dma_addr;
  assign dma_data = s_q.dma_data;
  assign irq = s_q.irq;
endmodule // ssir_top

/* tb/ssir_checker.sv */
// concurrent checks on the top ports of the spi status block
`timescale 1ns/1ps
module ssir_checker import ssir_pkg::*; (
  input wire logic clock, // system clock
  input wire logic sys_rst, // sync reset
  input wire logic [ADDR_W-1:0] reg_addr, // address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [31:0] reg_rdata, // read data
  input wire logic core_enable_cmd, // enable pulse
  input wire logic core_rx_load, // rx load pulse
  input wire logic core_tx_load, // tx load pulse
  input wire logic [3:0] slave_select_lines, // selects
  input wire logic [3:0] tx_select_field, // select field
  input wire logic tx_word_valid, // tx write pulse
  input wire logic [15:0] tx_word, // tx data
  input wire logic dma_wr, // store pulse
  input wire logic irq // interrupt
);
  logic [5:0] mask_q;
  logic [2:0] mode_q;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // shadows built from bus writes only, never from design state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mask_q <= 6'h00;
      mode_q <= 3'h0;
    end else if (reg_wr) begin
      if (reg_addr == OFF_IRQ_SET) mask_q <= mask_q | reg_wdata[5:0];
      if (reg_addr == OFF_IRQ_CLR) mask_q <= mask_q & ~reg_wdata[5:0];
      if (reg_addr == OFF_MODE_CTL) mode_q <= reg_wdata[2:0];
    end
  end
  sequence en_rd_s;
    core_enable_cmd ##2 (reg_rd && reg_addr == OFF_STATUS);
  endsequence
  sequence txw_rd_s;
    (reg_wr && reg_addr == OFF_TX_DATA && !core_tx_load) ##1 !core_tx_load
      ##1 (reg_rd && reg_addr == OFF_STATUS);
  endsequence
  idle_rdata_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data not idle");
  mask_read_a: assert property (
    reg_rd && reg_addr == OFF_IRQ_MASK |=> reg_rdata == {26'h0, mask_q})
    else $error("mask read wrong");
  dma_cause_a: assert property (
    dma_wr |-> $past(core_rx_load, 2)) else $error("store without load");
  tx_word_a: assert property (
    reg_wr && reg_addr == OFF_TX_DATA |=> tx_word_valid
      && tx_word == $past(reg_wdata[15:0])
      && tx_select_field == $past(reg_wdata[19:16]))
    else $error("tx word not passed on");
  irq_mask_a: assert property (
    irq |-> mask_q != 6'h00) else $error("irq with all masked");
  decode_sel_a: assert property (
    tx_word_valid && mode_q == 3'h7 |-> ##[0:2]
      slave_select_lines == tx_select_field) else $error("decode select");
  irq_reset_a: assert property (
    $fell(sys_rst) |-> !irq) else $error("irq after reset");
  enable_status_a: assert property (
    en_rd_s |=> reg_rdata[16] && reg_rdata[1]) else $error("enable status");
  tx_empty_clear_a: assert property (
    txw_rd_s |=> !reg_rdata[1]) else $error("tx empty not cleared");
endmodule // ssir_checker
bind ssir_top ssir_checker u_chk (.clock(clock), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_enable_cmd(core_enable_cmd),
  .core_rx_load(core_rx_load), .core_tx_load(core_tx_load),
  .slave_select_lines(slave_select_lines), .tx_select_field(tx_select_field),
  .tx_word_valid(tx_word_valid), .tx_word(tx_word), .dma_wr(dma_wr),
  .irq(irq));

/* tb/ssir_slave_model.sv */
// far-side slave devices: raise the fault level on bench request, after a lag
`timescale 1ns/1ps
module ssir_slave_model #(
  parameter int LAG = 3
) (
  input wire logic [3:0] slave_select_lines, // active-low selects
  input wire logic fault_req, // bench asks for a contending master
  output logic fault_pin // mode fault level
);
  // lag keeps the level unrelated to the system clock edges
  assign #LAG fault_pin = fault_req;
endmodule // ssir_slave_model

/* tb/spi_status_irq_rx_dma_regs_bench.sv */
// self-checking bench for the spi status and interrupt block
`timescale 1ns/1ps
module spi_status_irq_rx_dma_regs_bench import ssir_pkg::*; ;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic fault_req = 1'b0;
  logic clk_en = 1'b1;
  ssir_bus_t bus = '0;
  ssir_core_t core = '0;
  logic [31:0] rdata, dma_addr;
  logic [15:0] dma_data;
  logic [3:0] sel;
  logic dma_wr, irq, fault_pin;
  int fail_count = 0;
  int num_checks = 0;
  always #5 clock = ~clock;
  ssir_top DUT (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(bus.addr), .reg_wdata(bus.wdata), .reg_wr(bus.wr),
    .reg_rd(bus.rd), .reg_rdata(rdata), .core_enable_cmd(core.enable_cmd),
    .core_disable_cmd(core.disable_cmd), .core_rx_load(core.rx_load),
    .core_rx_word(core.rx_word), .core_tx_load(core.tx_load),
    .core_tx_done(core.tx_done), .fault_pin(fault_pin),
    .slave_select_lines(sel), .tx_select_field(), .tx_word_valid(),
    .tx_word(), .dma_wr(dma_wr), .dma_addr(dma_addr), .dma_data(dma_data),
    .irq(irq));
  ssir_slave_model u_slave (.slave_select_lines(sel), .fault_req(fault_req),
    .fault_pin(fault_pin));
  task automatic chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask
  task automatic rdck(input logic [7:0] a, input logic [31:0] e, string n);
    @(posedge clock);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 chk(n, rdata, e);
  endtask
  // one-cycle command pulses; tx_done is a level and stays as given
  task automatic cp(input logic en, dis, rxl, txl, txd, logic [15:0] w);
    @(posedge clock);
    core <= {en, dis, rxl, w, txl, 1'b0, txd};
    @(posedge clock);
    core <= {3'b0, w, 2'b0, txd};
  endtask
  task automatic selck(input logic [3:0] f, e);
    wr(OFF_TX_DATA, {12'h0, f, 16'h0055});
    repeat (3) @(posedge clock);
    #1 chk("select", {28'h0, sel}, {28'h0, e});
  endtask
  task automatic t_mask();
    cp(0, 0, 0, 0, 1, 16'h0);
    wr(OFF_IRQ_SET, 32'h3F);
    rdck(OFF_IRQ_MASK, 32'h3F, "mask set");
    chk("irq on", {31'h0, irq}, 32'h1);
    wr(OFF_IRQ_CLR, 32'h20);
    rdck(OFF_IRQ_MASK, 32'h1F, "mask clr");
    chk("irq off", {31'h0, irq}, 32'h0);
    wr(OFF_IRQ_CLR, 32'h0);
    wr(OFF_IRQ_SET, 32'h0);
    rdck(OFF_IRQ_MASK, 32'h1F, "mask zero wr");
    wr(OFF_IRQ_CLR, 32'h3F);
    wr(OFF_IRQ_MASK, 32'h3F);
    rdck(OFF_IRQ_MASK, 32'h0, "mask ro");
  endtask
  task automatic t_enable();
    cp(1, 0, 0, 0, 0, 16'h0);
    rdck(OFF_STATUS, 32'h10002, "enabled");
    wr(OFF_TX_DATA, 32'h1234);
    rdck(OFF_STATUS, 32'h10000, "tx written");
    cp(0, 0, 0, 1, 1, 16'h0);
    rdck(OFF_STATUS, 32'h10022, "tx moved");
    cp(0, 1, 0, 0, 0, 16'h0);
    rdck(OFF_STATUS, 32'h0, "disabled");
  endtask
  task automatic t_rx();
    wr(OFF_RX_ADDR, 32'h1000);
    wr(OFF_RX_COUNT, 32'h2);
    rdck(OFF_STATUS, 32'h0, "rx busy");
    for (int i = 0; i < 2; i++) begin
      cp(0, 0, 1, 0, 0, 16'(16'hA0 + i));
      #1;
      for (int n = 0; n < 4 && dma_wr !== 1'b1; n++) @(posedge clock) #1;
      chk("dma wr", {31'h0, dma_wr}, 32'h1);
      chk("dma addr", dma_addr, 32'h1000 + 4 * i);
      chk("dma data", {16'h0, dma_data}, 32'hA0 + i);
    end
    rdck(OFF_RX_ADDR, 32'h1008, "rx addr");
    rdck(OFF_STATUS, 32'h10, "rx done");
    cp(0, 0, 1, 0, 0, 16'h5A5A);
    rdck(OFF_STATUS, 32'h11, "rx full");
    cp(0, 0, 1, 0, 0, 16'hBEEF);
    rdck(OFF_STATUS, 32'h19, "overrun");
    rdck(OFF_STATUS, 32'h11, "overrun clr");
    rdck(OFF_RX_DATA, 32'hBEEF, "rx data");
    rdck(OFF_STATUS, 32'h10, "rx full clr");
    // a load while the clock enable is low must leave no trace
    @(posedge clock);
    clk_en <= 1'b0;
    cp(0, 0, 1, 0, 0, 16'h1111);
    @(posedge clock);
    clk_en <= 1'b1;
    rdck(OFF_STATUS, 32'h10, "frozen");
  endtask
  task automatic t_fault();
    @(posedge clock);
    fault_req <= 1'b1;
    repeat (6) @(posedge clock);
    rdck(OFF_STATUS, 32'h14, "fault");
    rdck(OFF_STATUS, 32'h10, "fault clr");
    fault_req <= 1'b0;
  endtask
  task automatic t_select();
    cp(1, 0, 0, 0, 0, 16'h0);
    wr(OFF_MODE_CTL, 32'h000F0003);
    for (int i = 0; i < 4; i++) selck(4'((1 << i) - 1), ~(4'h1 << i));
    wr(OFF_MODE_CTL, 32'h000F0007);
    selck(4'h5, 4'h5);
    rdck(OFF_RX_DATA, 32'h0005BEEF, "rx data sel");
    wr(OFF_MODE_CTL, 32'h000F0005);
    selck(4'h0, 4'hF);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    rdck(OFF_STATUS, 32'h0, "reset status");
    rdck(OFF_RX_COUNT, 32'h0, "reset count");
    rdck(8'h3C, 32'h0, "unmapped");
    t_mask();
    t_enable();
    t_rx();
    t_fault();
    t_select();
    test_done();
  end
  // the sequence needs under two hundred cycles; this cuts a hang short
  initial begin
    repeat (3000) @(posedge clock);
    fail_count++;
    test_done();
  end
endmodule // spi_status_irq_rx_dma_regs_bench
